// ---- design/spi_cfg_status.sv ----
// Serial port with config/status register on an Avalon-MM slave
// What this block does
// [R1] Busy bit is high while a transfer runs, master or slave.
// [R2] Master enable 0 makes the port a slave, 1 a master.
// [R3] Clock phase 0 centres data on first edge, 1 on second edge.
// [R4] Clock polarity 0 idles the clock low, 1 idles it high.
// [R5] Selected flag is the inverse of the deglitched select pin.
// [R6] Raw select bit returns the undeglitched pin level at read time.
// [R7] In slave mode shift-empty sets once shifter and transmit buffer hold nothing.
// [R8] Shift-empty clears on load or clock edge, reads 1 in master mode.
// [R9] In slave mode receive-empty is 0 while unread data is held.
// [R10] In master mode receive-empty always reads 1.
// [R11] Slave samples master-out data at the centre of each bit.
// [R12] Master samples slave-out data just before each bit ends.
// [R13] Status bits are read-only, reset to 0,0,1,1,1.
// [R14] Writes change only master enable, phase and polarity.
`timescale 1ns/1ps
`default_nettype none
module spi_cfg_status (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire spi_cfg_pkg::addr_t AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire spi_cfg_pkg::word_t AVS_WRITEDATA_I,
  input wire spi_cfg_pkg::be_t AVS_BYTEENABLE_I,
  output spi_cfg_pkg::word_t AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output spi_cfg_pkg::resp_t AVS_RESPONSE_O,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_O,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE_O,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE_O,
  input wire logic SS_N_I
);
  import spi_cfg_pkg::*;

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  logic wait_r;
  word_t rdata_r;
  resp_t resp_r;
  logic master_en_r, cpha_r, cpol_r;
  byte_t div_r;
  byte_t tx_buf_r, rx_buf_r, sr_r;
  logic tx_full_r, rx_full_r, sr_full_r, shift_empty_r;
  logic ss_filt_r;
  bitcnt_t ss_cnt_r, bit_cnt_r;
  logic sck_prev_r;
  mstate_t mstate_r;
  byte_t div_cnt_r;
  half_t half_r;
  logic sck_r, sck_oe_r, mosi_r, mosi_oe_r, miso_r, miso_oe_r;
  logic req, accept, take, hit, be0;
  logic cfg_hit, ctrl_hit, data_hit;
  logic sck_lvl, mosi_lvl, miso_lvl, raw_ss, selected;
  logic sck_edge, lead, sample_edge;
  logic slave_act, s_sample, s_done, s_load;
  logic m_run, m_tick, m_end_bit, m_last, m_start;
  logic din, rx_pulse, tx_take, busy;
  byte_t cfg_rd, rx_byte;
  word_t rd_val;

  // --------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------
  pin_if pif();
  assign pif.pins = {SS_N_I, MISO_I, MOSI_I, SCK_I};
  pin_sync u_sync (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .p(pif)
  );
  assign sck_lvl = pif.lvl[PIN_SCK];
  assign mosi_lvl = pif.lvl[PIN_MOSI];
  assign miso_lvl = pif.lvl[PIN_MISO];
  assign raw_ss = pif.raw[PIN_SS]; // R6

  // Select must hold a new level for several cycles before it counts
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ss_filt_r <= 1'b1; // R13
      ss_cnt_r <= '0;
    end else if (pif.lvl[PIN_SS] == ss_filt_r) begin
      ss_cnt_r <= '0;
    end else if (ss_cnt_r == DEGLITCH_CYC) begin
      ss_filt_r <= pif.lvl[PIN_SS]; // R5
      ss_cnt_r <= '0;
    end else begin
      ss_cnt_r <= ss_cnt_r + 3'h1;
    end
  end
  assign selected = ~ss_filt_r; // R5

  // --------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign accept = req & wait_r;
  assign take = req & ~wait_r;
  assign cfg_hit = (AVS_ADDRESS_I == CFG_OFS);
  assign ctrl_hit = (AVS_ADDRESS_I == CTRL_OFS);
  assign data_hit = (AVS_ADDRESS_I == DATA_OFS);
  assign hit = cfg_hit | ctrl_hit | data_hit;
  assign be0 = AVS_BYTEENABLE_I[0];

  assign cfg_rd = {busy, master_en_r, cpha_r, cpol_r, selected, raw_ss,
                   master_en_r | shift_empty_r, master_en_r | ~rx_full_r}; // R8 R10 R9

  always_comb begin
    rd_val = '0;
    if (cfg_hit) begin
      rd_val = word_t'(cfg_rd);
    end else if (ctrl_hit) begin
      rd_val = word_t'(div_r);
    end else if (data_hit) begin
      rd_val = word_t'(rx_buf_r);
    end
  end

  // One wait cycle per access; read data is caught on the first edge
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
      resp_r <= RESP_OKAY;
    end else if (accept) begin
      wait_r <= 1'b0;
      rdata_r <= AVS_READ_I ? rd_val : '0;
      resp_r <= hit ? RESP_OKAY : RESP_SLVERR;
    end else begin
      wait_r <= 1'b1;
    end
  end
  assign AVS_WAITREQUEST_O = wait_r;
  assign AVS_READDATA_O = rdata_r;
  assign AVS_RESPONSE_O = resp_r;

  // Status bits have no write path at all
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      master_en_r <= CFG_RESET[MASTER_ENABLE_BIT];
      cpha_r <= CFG_RESET[CPHA_BIT];
      cpol_r <= CFG_RESET[CPOL_BIT];
    end else if (take & AVS_WRITE_I & cfg_hit & be0) begin
      master_en_r <= AVS_WRITEDATA_I[MASTER_ENABLE_BIT]; // R14 R2
      cpha_r <= AVS_WRITEDATA_I[CPHA_BIT]; // R14
      cpol_r <= AVS_WRITEDATA_I[CPOL_BIT]; // R14
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      div_r <= DIV_RESET;
    end else if (take & AVS_WRITE_I & ctrl_hit & be0) begin
      div_r <= AVS_WRITEDATA_I[7:0];
    end
  end

  // Writes while the buffer is full are dropped
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      tx_full_r <= 1'b0;
      tx_buf_r <= '0;
    end else if (tx_take) begin
      tx_full_r <= 1'b0;
    end else if (take & AVS_WRITE_I & data_hit & be0 & ~tx_full_r) begin
      tx_buf_r <= AVS_WRITEDATA_I[7:0];
      tx_full_r <= 1'b1;
    end
  end

  // A byte that lands on the read edge wins over the read clear
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rx_full_r <= 1'b0;
      rx_buf_r <= '0;
    end else if (rx_pulse) begin
      rx_buf_r <= rx_byte;
      rx_full_r <= 1'b1; // R9
    end else if (accept & AVS_READ_I & data_hit) begin
      rx_full_r <= 1'b0; // R9
    end
  end

  // --------------------------------------------------------------
  // Serial engine
  // --------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      sck_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= sck_lvl;
    end
  end
  assign sck_edge = sck_lvl ^ sck_prev_r;
  assign lead = sck_edge & (sck_lvl != cpol_r); // R4
  assign sample_edge = sck_edge & (lead ^ cpha_r); // R3
  assign slave_act = ~master_en_r & selected; // R2
  assign s_sample = slave_act & sample_edge; // R11
  assign s_done = s_sample & (bit_cnt_r == BIT_LAST);
  assign s_load = ~master_en_r & ~sr_full_r & tx_full_r & ~sck_edge &
                  (bit_cnt_r == '0);
  assign m_run = (mstate_r == M_RUN);
  assign m_tick = m_run & (div_cnt_r == '0);
  assign m_end_bit = m_tick & (cpha_r ? (~half_r[0] & (half_r != '0))
                                      : half_r[0]); // R12 R3
  assign m_last = m_tick & (half_r == (cpha_r ? HALF_LAST_PH1 : HALF_LAST_PH0));
  assign m_start = ~m_run & master_en_r & tx_full_r; // R2
  assign tx_take = m_start | s_load;
  assign din = master_en_r ? miso_lvl : mosi_lvl;
  assign rx_byte = {sr_r[6:0], din};
  assign rx_pulse = s_done | m_last;
  assign busy = m_run | (slave_act & (bit_cnt_r != '0)); // R1

  // Master sequencer: half periods of div+1 system clocks
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mstate_r <= M_IDLE;
      div_cnt_r <= '0;
      half_r <= '0;
    end else begin
      unique case (mstate_r)
        M_IDLE: begin
          if (m_start) begin
            mstate_r <= M_RUN; // R1
            div_cnt_r <= div_r;
            half_r <= '0;
          end
        end
        M_RUN: begin
          if (!m_tick) begin
            div_cnt_r <= div_cnt_r - 8'h01;
          end else if (m_last) begin
            mstate_r <= M_IDLE;
          end else begin
            div_cnt_r <= div_r;
            half_r <= half_r + 5'h01;
          end
        end
      endcase
    end
  end

  // One shifter serves both modes; the mode bit picks the data pin
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      sr_r <= '0;
    end else if (tx_take) begin
      sr_r <= tx_buf_r;
    end else if (m_end_bit | s_sample) begin
      sr_r <= rx_byte; // R11 R12
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      bit_cnt_r <= '0;
      sr_full_r <= 1'b0;
    end else begin
      if (!slave_act) begin
        bit_cnt_r <= '0;
      end else if (s_sample) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (master_en_r) begin
        sr_full_r <= 1'b0;
      end else if (s_load) begin
        sr_full_r <= 1'b1;
      end else if (s_done) begin
        sr_full_r <= 1'b0;
      end
    end
  end

  // Idle with nothing loaded or pending reads back as empty
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      shift_empty_r <= CFG_RESET[SHIFT_EMPTY_BIT]; // R13
    end else if (master_en_r) begin
      shift_empty_r <= 1'b1; // R8
    end else if (s_load | (slave_act & sck_edge)) begin
      shift_empty_r <= 1'b0; // R8
    end else if ((bit_cnt_r == '0) & ~sr_full_r & ~tx_full_r) begin
      shift_empty_r <= 1'b1; // R7
    end
  end

  // --------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      sck_oe_r <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      sck_oe_r <= master_en_r; // R2
      mosi_oe_r <= master_en_r; // R2
      miso_oe_r <= slave_act; // R2
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      sck_r <= CFG_RESET[CPOL_BIT];
    end else if (!m_run) begin
      sck_r <= cpol_r; // R4
    end else if (m_tick & (half_r <= HALF_LAST_PH0)) begin
      sck_r <= ~sck_r;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mosi_r <= 1'b0;
    end else if (m_start & ~cpha_r) begin
      mosi_r <= tx_buf_r[7]; // R3
    end else if (m_tick & cpha_r & (half_r == '0)) begin
      mosi_r <= sr_r[7]; // R3
    end else if (m_end_bit & ~m_last) begin
      mosi_r <= sr_r[6];
    end
  end

  // Bit 7 stands from the load. Sync latency is near half a link period,
  // so the next bit goes out on the sample edge and lands by the far
  // side's next sample; waiting for the shift edge would come too late
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      miso_r <= 1'b0;
    end else if (s_load) begin
      miso_r <= tx_buf_r[7]; // R3
    end else if (s_sample) begin
      miso_r <= sr_r[6]; // R3
    end
  end

  assign SCK_O = sck_r;
  assign SCK_OE_O = sck_oe_r;
  assign MOSI_O = mosi_r;
  assign MOSI_OE_O = mosi_oe_r;
  assign MISO_O = miso_r;
  assign MISO_OE_O = miso_oe_r;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_busy_master: // R1
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    m_start |=> cfg_rd[BUSY_BIT] [*8])
    else $error("busy not held during master transfer");

  a_mode_drive: // R2
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    master_en_r |=> SCK_OE_O && MOSI_OE_O && !MISO_OE_O)
    else $error("master mode does not drive clock and data out");

  a_phase_first: // R3
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    (m_start && !cpha_r) |=> (MOSI_O == $past(tx_buf_r[7])))
    else $error("phase 0 first bit not presented at start");

  a_idle_level: // R4
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    (mstate_r == M_IDLE) |=> (SCK_O == $past(cpol_r)))
    else $error("idle clock level differs from polarity");

  a_sel_filter: // R5
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!pif.lvl[PIN_SS]) [*6] |=> cfg_rd[SEL_BIT])
    else $error("selected flag missing after steady low select");

  a_raw_read: // R6
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    (accept && AVS_READ_I && cfg_hit) |=>
      (AVS_READDATA_O[RAW_BIT] == $past(raw_ss)))
    else $error("raw select bit not the pin level at read");

  a_shift_empty_idle: // R7
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    (!master_en_r && bit_cnt_r == '0 && !sr_full_r && !tx_full_r &&
     !(slave_act && sck_edge)) |=> shift_empty_r)
    else $error("shift empty not set when idle");

  a_shift_empty_master: // R8
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    (master_en_r && $past(master_en_r)) |-> cfg_rd[SHIFT_EMPTY_BIT] && shift_empty_r)
    else $error("shift empty low in master mode");

  a_rx_slave: // R9
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    (rx_pulse && !master_en_r && !(take && cfg_hit && AVS_WRITE_I))
      |=> !cfg_rd[RECEIVE_EMPTY_BIT])
    else $error("receive empty not cleared by new byte");

  a_rx_master: // R10
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    master_en_r |-> cfg_rd[RECEIVE_EMPTY_BIT])
    else $error("receive empty low in master mode");

  a_reset_vals: // R13
  assert property (@(posedge CLK_I)
    $past(SRST_I) |-> (cfg_rd == CFG_RESET))
    else $error("config status value wrong after reset");

  a_write_cfg: // R14
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    (take && AVS_WRITE_I && cfg_hit && be0) |=>
      ({master_en_r, cpha_r, cpol_r} == $past(AVS_WRITEDATA_I[6:4])))
    else $error("config write not stored");

  a_bus_wait: // one wait cycle per access
  assert property (@(posedge CLK_I) disable iff (SRST_I)
    accept |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("wait request not one cycle");
endmodule // spi_cfg_status
`default_nettype wire

// ---- common/spi_cfg_pkg.sv ----
// Shared constants and types for the serial port config/status block
package spi_cfg_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0] byte_t;
  typedef logic [7:0] addr_t;
  typedef logic [3:0] be_t;
  typedef logic [1:0] resp_t;
  typedef logic [4:0] half_t;
  typedef logic [2:0] bitcnt_t;
  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam addr_t CTRL_OFS = 8'h80;
  localparam addr_t CFG_OFS = 8'h84;
  localparam addr_t DATA_OFS = 8'h88;
  localparam int BUSY_BIT = 7;
  localparam int MASTER_ENABLE_BIT = 6;
  localparam int CPHA_BIT = 5;
  localparam int CPOL_BIT = 4;
  localparam int SEL_BIT = 3;
  localparam int RAW_BIT = 2;
  localparam int SHIFT_EMPTY_BIT = 1;
  localparam int RECEIVE_EMPTY_BIT = 0;
  localparam byte_t CFG_RESET = 8'h07;
  localparam byte_t DIV_RESET = 8'h04;
  localparam resp_t RESP_OKAY = 2'h0;
  localparam resp_t RESP_SLVERR = 2'h2;
  // --------------------------------------------------------------
  // Pins and timing
  // --------------------------------------------------------------
  localparam int N_PINS = 4;
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SS = 3;
  localparam logic [3:0] PIN_RESET = 4'h8;
  localparam bitcnt_t DEGLITCH_CYC = 3'h4;
  localparam bitcnt_t BIT_LAST = 3'h7;
  localparam half_t HALF_LAST_PH0 = 5'h0F;
  localparam half_t HALF_LAST_PH1 = 5'h10;
  typedef enum logic [0:0] {M_IDLE = 1'b0, M_RUN = 1'b1} mstate_t;
endpackage

// ---- common/pin_if.sv ----
// Pin levels between the top module and its input synchroniser
`timescale 1ns/1ps
`default_nettype none
interface pin_if;
  import spi_cfg_pkg::*;
  logic [N_PINS-1:0] pins;
  logic [N_PINS-1:0] raw;
  logic [N_PINS-1:0] lvl;
  modport src(input pins, output raw, output lvl);
  modport dst(output pins, input raw, input lvl);
endinterface
`default_nettype wire

// ---- design/pin_sync.sv ----
// Three-stage synchroniser with agreement filter for each serial pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk_i,
  input wire logic srst_i,
  pin_if.src p
);
  import spi_cfg_pkg::*;
  logic [N_PINS-1:0] s1_r;
  logic [N_PINS-1:0] s2_r;
  logic [N_PINS-1:0] s3_r;
  logic [N_PINS-1:0] lvl_r;
  genvar i;
  generate
    for (i = 0; i < N_PINS; i++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          s1_r[i] <= PIN_RESET[i];
          s2_r[i] <= PIN_RESET[i];
          s3_r[i] <= PIN_RESET[i];
          lvl_r[i] <= PIN_RESET[i];
        end else begin
          s1_r[i] <= p.pins[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          // Change counts only once stages two and three agree
          if (s2_r[i] == s3_r[i]) begin
            lvl_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
  assign p.raw = s2_r;
  assign p.lvl = lvl_r;
endmodule // pin_sync
`default_nettype wire

// ---- bench/spi_far_model.sv ----
// Far-side serial device model: acts as slave or as master of the link
`timescale 1ns/1ps
`default_nettype none
module spi_far_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic miso_o,
  output logic ss_n_o
);
  import spi_cfg_pkg::*;
  logic cpol;
  logic cpha;
  logic slave_on;
  byte_t tx;
  byte_t rx;
  initial begin
    cpol = 1'h0;
    cpha = 1'h0;
    slave_on = 1'h0;
    tx = 8'h00;
    rx = 8'h00;
    sck_o = 1'h0;
    mosi_o = 1'h0;
    miso_o = 1'h0;
    ss_n_o = 1'h1;
  end
  // --------------------------------------------------------------
  // Slave role
  // --------------------------------------------------------------
  task automatic arm_slave(input logic pol, input logic pha, input byte_t b);
    cpol = pol;
    cpha = pha;
    tx = b;
    rx = 8'h00;
    slave_on = 1'h1;
    // Phase 1 shows nothing valid before the first leading edge
    miso_o = pha ? ~miso_o : b[7];
  endtask
  task automatic release_slave();
    slave_on = 1'h0;
    miso_o = ~miso_o;
  endtask
  always @(sck_i) begin
    if (slave_on) begin
      if ((sck_i != cpol) == !cpha) begin
        rx = {rx[6:0], mosi_i};
      end else begin
        if (!cpha) tx = {tx[6:0], 1'h0};
        miso_o = tx[7];
        if (cpha) tx = {tx[6:0], 1'h0};
      end
    end
  end
  // --------------------------------------------------------------
  // Master role, 80 ns link period, clock still outside frames
  // --------------------------------------------------------------
  task automatic run_master(input logic pol, input logic pha, input byte_t b,
                            output byte_t got);
    int i;
    got = 8'h00;
    // Off the system clock edges so the pins never race the sampler
    #3;
    sck_o = pol;
    #100 ss_n_o = 1'h0;
    #200;
    for (i = 7; i >= 0; i--) begin
      if (!pha) mosi_o = b[i];
      #40 sck_o = ~pol;
      if (pha) mosi_o = b[i];
      else got = {got[6:0], miso_i};
      #40 sck_o = pol;
      if (pha) got = {got[6:0], miso_i};
    end
    #200 ss_n_o = 1'h1;
    mosi_o = ~mosi_o;
  endtask
endmodule // spi_far_model
`default_nettype wire

// ---- bench/spi_cfg_status_tb_top.sv ----
// Self-checking bench for the serial port config/status block
`timescale 1ns/1ps
`default_nettype none
module spi_cfg_status_tb_top;
  import spi_cfg_pkg::*;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
  logic clk;
  logic srst;
  addr_t avs_addr;
  logic avs_rd;
  logic avs_wr;
  word_t avs_wdata;
  be_t avs_be;
  word_t avs_rdata;
  logic avs_wait;
  resp_t avs_resp;
  word_t rdata;
  resp_t resp;
  wire logic sck_w;
  wire logic mosi_w;
  wire logic miso_w;
  logic m_sck, m_mosi, m_miso, m_ss_n;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  int n_mismatch;
  int n_checks;
  byte_t lfsr, tx_b, far_b, got;
  logic pol, pha;
  int k;
  assign sck_w = sck_oe ? sck_o : m_sck;
  assign mosi_w = mosi_oe ? mosi_o : m_mosi;
  assign miso_w = miso_oe ? miso_o : m_miso;
  spi_cfg_status DUT (.CLK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(avs_addr),
    .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr), .AVS_WRITEDATA_I(avs_wdata),
    .AVS_BYTEENABLE_I(avs_be), .AVS_READDATA_O(avs_rdata),
    .AVS_WAITREQUEST_O(avs_wait), .AVS_RESPONSE_O(avs_resp), .SCK_I(sck_w),
    .SCK_O(sck_o), .SCK_OE_O(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
    .MOSI_OE_O(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE_O(miso_oe),
    .SS_N_I(m_ss_n));
  spi_far_model u_far (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
    .sck_o(m_sck), .mosi_o(m_mosi), .miso_o(m_miso), .ss_n_o(m_ss_n));
  always #5 clk = ~clk;
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic byte_t lfsr_step(input byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic word_t cfg_word(input logic busy, input logic [2:0] m,
                                     input logic [3:0] st);
    return {24'h000000, busy, m, st};
  endfunction
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One access; released after the accepting edge, then one idle edge
  task automatic bus_xfer(input logic wr, input addr_t a, input word_t d, input be_t be);
    int n;
    n = 0;
    avs_addr <= a;
    avs_wdata <= d;
    avs_be <= be;
    avs_wr <= wr;
    avs_rd <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_wait !== 1'h0 && n < 40);
    if (n >= 40) n_mismatch++;
    rdata = avs_rdata;
    resp = avs_resp;
    avs_wr <= 1'h0;
    avs_rd <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input addr_t a, input word_t e, input string nm);
    bus_xfer(1'h0, a, 32'h00000000, 4'hF);
    `CHK(nm, e, rdata)
    `CHK("read resp", RESP_OKAY, resp)
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus_xfer(1'h0, CFG_OFS, 32'h00000000, 4'hF);
      n++;
    end while (rdata[7] !== 1'h0 && n < 200);
    if (n >= 200) n_mismatch++;
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    clk = 1'h0;
    srst = 1'h1;
    avs_addr = 8'h00;
    avs_rd = 1'h0;
    avs_wr = 1'h0;
    avs_wdata = 32'h00000000;
    avs_be = 4'hF;
    n_mismatch = 0;
    n_checks = 0;
    lfsr = 8'h1E;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    rd_chk(CFG_OFS, cfg_word(1'h0, 3'h0, 4'h7), "cfg reset");
    bus_xfer(1'h1, CFG_OFS, 32'h000000FF, 4'hF);
    rd_chk(CFG_OFS, cfg_word(1'h0, 3'h7, 4'h7), "cfg all");
    bus_xfer(1'h1, CFG_OFS, 32'h0000008F, 4'hF);
    rd_chk(CFG_OFS, cfg_word(1'h0, 3'h0, 4'h7), "cfg ro");
    bus_xfer(1'h1, CFG_OFS, 32'h00000070, 4'h0);
    rd_chk(CFG_OFS, cfg_word(1'h0, 3'h0, 4'h7), "cfg no lane");
    bus_xfer(1'h0, 8'hF0, 32'h00000000, 4'hF);
    `CHK("unmapped resp", RESP_SLVERR, resp)
    `CHK("unmapped data", 32'h00000000, rdata)
    bus_xfer(1'h1, 8'hF0, 32'h000000FF, 4'hF);
    `CHK("unmapped wr resp", RESP_SLVERR, resp)
    rd_chk(CTRL_OFS, {24'h000000, DIV_RESET}, "div reset");
    rd_chk(CFG_OFS, cfg_word(1'h0, 3'h0, 4'h7), "cfg after unmapped");
    for (k = 0; k < 4; k++) begin
      pol = k[0];
      pha = k[1];
      bus_xfer(1'h1, CFG_OFS, cfg_word(1'h0, {1'h1, pha, pol}, 4'h0), 4'hF);
      @(negedge clk);
      `CHK("sck idle", pol, sck_o)
      `CHK("sck drive", 1'h1, sck_oe)
      @(posedge clk);
      lfsr = lfsr_step(lfsr);
      far_b = lfsr;
      lfsr = lfsr_step(lfsr);
      tx_b = lfsr;
      u_far.arm_slave(pol, pha, far_b);
      bus_xfer(1'h1, DATA_OFS, {24'h000000, tx_b}, 4'hF);
      rd_chk(CFG_OFS, cfg_word(1'h1, {1'h1, pha, pol}, 4'h7), "cfg run");
      wait_idle();
      `CHK("far rx", tx_b, u_far.rx)
      rd_chk(DATA_OFS, {24'h000000, far_b}, "master rx");
      rd_chk(CFG_OFS, cfg_word(1'h0, {1'h1, pha, pol}, 4'h7), "cfg end");
      u_far.release_slave();
    end
    for (k = 0; k < 4; k++) begin
      pol = k[0];
      pha = k[1];
      bus_xfer(1'h1, CFG_OFS, cfg_word(1'h0, {1'h0, pha, pol}, 4'h0), 4'hF);
      @(negedge clk);
      `CHK("sck released", 1'h0, sck_oe)
      @(posedge clk);
      lfsr = lfsr_step(lfsr);
      far_b = lfsr;
      lfsr = lfsr_step(lfsr);
      tx_b = lfsr;
      bus_xfer(1'h1, DATA_OFS, {24'h000000, tx_b}, 4'hF);
      fork
        u_far.run_master(pol, pha, far_b, got);
        begin
          repeat (60) @(posedge clk);
          rd_chk(CFG_OFS, cfg_word(1'h1, {1'h0, pha, pol}, 4'h9), "cfg mid");
        end
      join
      repeat (20) @(posedge clk);
      rd_chk(CFG_OFS, cfg_word(1'h0, {1'h0, pha, pol}, 4'h6), "cfg done");
      `CHK("far got", tx_b, got)
      rd_chk(DATA_OFS, {24'h000000, far_b}, "slave rx");
      rd_chk(CFG_OFS, cfg_word(1'h0, {1'h0, pha, pol}, 4'h7), "cfg drained");
    end
    report_and_stop();
  end
  // Whole run is about 10 us; a hang ends here
  initial begin
    #300000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // spi_cfg_status_tb_top
`default_nettype wire
